//--- inc/lcd_drv_pkg.sv
// Purpose: shared constants and types for the lcd segment/common driver core
// Assumes: one parallel capture word is one 8-bit bus group; in 4-bit mode two words make one
// Notes: level codes name the four drive rails; the analog stage maps them
package lcd_drv_pkg;
  localparam int NUM_OUTPUTS = 160;
  localparam int GROUP_WIDTH = 8;
  localparam int NIBBLE_WIDTH = 4;
  localparam int NUM_GROUPS = 20;
  localparam int GROUP_CNT_WIDTH = 5;
  localparam logic [4:0] LAST_GROUP = 5'h13;
  localparam logic [4:0] FIRST_GROUP = 5'h00;
  localparam int LEVEL_WIDTH = 2;
  localparam int SYNC_WIDTH = 9;
  // positions inside the synchroniser vector
  localparam int SYNC_TOGGLE = 0;
  localparam int SYNC_STROBE = 1;
  localparam int SYNC_CASC_A = 2;
  localparam int SYNC_CASC_B = 3;
  localparam int SYNC_BLANK_N = 4;
  localparam int SYNC_SEG_MODE = 5;
  localparam int SYNC_DIR = 6;
  localparam int SYNC_WIDE = 7;
  localparam int SYNC_POLARITY = 8;

  typedef enum logic [1:0] {
    LEVEL_BIAS_TOP = 2'h0,
    LEVEL_BIAS_UPPER_MID = 2'h1,
    LEVEL_BIAS_LOWER_MID = 2'h2,
    LEVEL_VSS = 2'h3
  } level_type;

  // gray along idle -> selected -> done
  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_SELECTED = 2'h1,
    CAP_DONE = 2'h3
  } cap_state_type;
endpackage

//--- src/lcd_seg_com_driver_logic.sv
// Purpose: digital core of a 160-output lcd segment/common driver
// Assumes: pixel clock is a separate domain that stops between lines
// Notes: cascade select is active low; level codes leave on lcd_outputs_o
`timescale 1ns/100ps
`default_nettype none
module lcd_seg_com_driver_logic #(
  parameter int NUM_OUTPUTS = lcd_drv_pkg::NUM_OUTPUTS,
  parameter int GROUP_WIDTH = lcd_drv_pkg::GROUP_WIDTH
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pixel_shift_clock_i,
  input wire logic [GROUP_WIDTH-1:0] pixel_in_i,
  input wire logic line_strobe_i,
  input wire logic ac_polarity_in_i,
  input wire logic blank_outputs_n_i,
  input wire logic bus_width_select_i,
  input wire logic segment_mode_i,
  input wire logic fill_direction_i,
  input wire logic cascade_io_a_i,
  output logic cascade_io_a_o,
  output logic cascade_io_a_oe_o,
  input wire logic cascade_io_b_i,
  output logic cascade_io_b_o,
  output logic cascade_io_b_oe_o,
  output logic [NUM_OUTPUTS*lcd_drv_pkg::LEVEL_WIDTH-1:0] lcd_outputs_o
);
  localparam int SW = lcd_drv_pkg::SYNC_WIDTH;
  localparam int NW = lcd_drv_pkg::NIBBLE_WIDTH;
  localparam int LW = lcd_drv_pkg::LEVEL_WIDTH;

  // ==========================================================
  // pixel clock domain
  // ==========================================================
  logic [GROUP_WIDTH-1:0] sample_ff;
  logic sample_tog_ff;
  always_ff @(negedge pixel_shift_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_ff <= '0;
      sample_tog_ff <= 1'b0;
    end else begin
      sample_ff <= pixel_in_i;
      sample_tog_ff <= ~sample_tog_ff;
    end
  end

  // ==========================================================
  // input synchronisers
  // ==========================================================
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic [SW-1:0] sync3_ff;
  logic [SW-1:0] stable_ff;
  logic [SW-1:0] nxt_stable;
  assign raw_in[lcd_drv_pkg::SYNC_TOGGLE] = sample_tog_ff;
  assign raw_in[lcd_drv_pkg::SYNC_STROBE] = line_strobe_i;
  assign raw_in[lcd_drv_pkg::SYNC_CASC_A] = cascade_io_a_i;
  assign raw_in[lcd_drv_pkg::SYNC_CASC_B] = cascade_io_b_i;
  assign raw_in[lcd_drv_pkg::SYNC_BLANK_N] = blank_outputs_n_i;
  assign raw_in[lcd_drv_pkg::SYNC_SEG_MODE] = segment_mode_i;
  assign raw_in[lcd_drv_pkg::SYNC_DIR] = fill_direction_i;
  assign raw_in[lcd_drv_pkg::SYNC_WIDE] = bus_width_select_i;
  assign raw_in[lcd_drv_pkg::SYNC_POLARITY] = ac_polarity_in_i;
  // a change counts once the second and third stage agree
  assign nxt_stable = (sync2_ff & sync3_ff) | (stable_ff & (sync2_ff | sync3_ff));
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      stable_ff <= '0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      stable_ff <= nxt_stable;
    end
  end
  wire seg_mode = stable_ff[lcd_drv_pkg::SYNC_SEG_MODE];
  wire ac_pol = stable_ff[lcd_drv_pkg::SYNC_POLARITY];
  wire dir_high = stable_ff[lcd_drv_pkg::SYNC_DIR];
  wire wide_bus = stable_ff[lcd_drv_pkg::SYNC_WIDE];
  wire blank_n = stable_ff[lcd_drv_pkg::SYNC_BLANK_N];
  wire casc_a = stable_ff[lcd_drv_pkg::SYNC_CASC_A];
  wire casc_b = stable_ff[lcd_drv_pkg::SYNC_CASC_B];
  wire strobe_fall = stable_ff[lcd_drv_pkg::SYNC_STROBE] & ~nxt_stable[lcd_drv_pkg::SYNC_STROBE];
  wire sample_evt = stable_ff[lcd_drv_pkg::SYNC_TOGGLE] ^ nxt_stable[lcd_drv_pkg::SYNC_TOGGLE];
  // direction high: a is the input side, b the output side
  wire casc_in = dir_high ? casc_a : casc_b;

  // ==========================================================
  // capture sequencing
  // ==========================================================
  // places one byte at its group slot; low direction mirrors order
  function automatic logic [NUM_OUTPUTS-1:0] place_group(
    input logic [NUM_OUTPUTS-1:0] latch,
    input logic [GROUP_WIDTH-1:0] grp_data,
    input logic [lcd_drv_pkg::GROUP_CNT_WIDTH-1:0] grp,
    input logic dir
  );
    logic [NUM_OUTPUTS-1:0] res;
    int pos;
    res = latch;
    for (int i = 0; i < GROUP_WIDTH; i++) begin
      pos = int'(grp) * GROUP_WIDTH + i;
      if (dir) begin
        res[pos] = grp_data[i];
      end else begin
        res[NUM_OUTPUTS-1-pos] = grp_data[i];
      end
    end
    return res;
  endfunction

  lcd_drv_pkg::cap_state_type state_ff;
  lcd_drv_pkg::cap_state_type nxt_state;
  logic [lcd_drv_pkg::GROUP_CNT_WIDTH-1:0] group_cnt_ff;
  logic [lcd_drv_pkg::GROUP_CNT_WIDTH-1:0] nxt_group_cnt;
  logic half_ff;
  logic nxt_half;
  logic [NW-1:0] low_nibble_ff;
  logic [NUM_OUTPUTS-1:0] data_latch_ff;
  logic [NUM_OUTPUTS-1:0] nxt_data_latch;
  wire take_sample = seg_mode & sample_evt & (state_ff == lcd_drv_pkg::CAP_SELECTED);
  // 8-bit mode: every sample is a group; 4-bit: second nibble completes it
  wire group_ready = take_sample & (wide_bus | half_ff);
  wire [GROUP_WIDTH-1:0] group_data = wide_bus ? sample_ff :
    GROUP_WIDTH'({sample_ff[NW-1:0], low_nibble_ff});
  wire last_group = group_cnt_ff == lcd_drv_pkg::LAST_GROUP;
  assign nxt_data_latch = group_ready ?
    place_group(data_latch_ff, group_data, group_cnt_ff, dir_high) : data_latch_ff;
  always_comb begin
    nxt_state = state_ff;
    nxt_group_cnt = group_cnt_ff;
    nxt_half = half_ff;
    if (strobe_fall) begin
      nxt_state = lcd_drv_pkg::CAP_IDLE;
      nxt_group_cnt = lcd_drv_pkg::FIRST_GROUP;
      nxt_half = 1'b0;
    end else begin
      case (state_ff)
        lcd_drv_pkg::CAP_IDLE: begin
          if (seg_mode && !casc_in) begin
            nxt_state = lcd_drv_pkg::CAP_SELECTED;
          end
        end
        lcd_drv_pkg::CAP_SELECTED: begin
          if (take_sample && !wide_bus) begin
            nxt_half = ~half_ff;
          end
          if (group_ready) begin
            if (last_group) begin
              nxt_state = lcd_drv_pkg::CAP_DONE;
            end else begin
              nxt_group_cnt = group_cnt_ff + 5'h01;
            end
          end
        end
        lcd_drv_pkg::CAP_DONE: begin
          nxt_state = lcd_drv_pkg::CAP_DONE;
        end
        default: begin
          nxt_state = lcd_drv_pkg::CAP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= lcd_drv_pkg::CAP_IDLE;
      group_cnt_ff <= lcd_drv_pkg::FIRST_GROUP;
      half_ff <= 1'b0;
      low_nibble_ff <= '0;
      data_latch_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      group_cnt_ff <= nxt_group_cnt;
      half_ff <= nxt_half;
      low_nibble_ff <= (take_sample && !half_ff) ? sample_ff[NW-1:0] : low_nibble_ff;
      data_latch_ff <= nxt_data_latch;
    end
  end

  // ==========================================================
  // line latch / common shift register
  // ==========================================================
  logic [NUM_OUTPUTS-1:0] line_ff;
  logic [NUM_OUTPUTS-1:0] nxt_line;
  wire [NUM_OUTPUTS-1:0] shifted = dir_high ?
    {line_ff[NUM_OUTPUTS-2:0], casc_a} : {casc_b, line_ff[NUM_OUTPUTS-1:1]};
  assign nxt_line = !blank_n ? '0 :
    !strobe_fall ? line_ff :
    seg_mode ? data_latch_ff : shifted;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_ff <= '0;
    end else begin
      line_ff <= nxt_line;
    end
  end

  // ==========================================================
  // cascade pins
  // ==========================================================
  wire cs_out_n = state_ff != lcd_drv_pkg::CAP_DONE;
  wire casc_out = seg_mode ? cs_out_n :
    (dir_high ? line_ff[NUM_OUTPUTS-1] : line_ff[0]);

  assign cascade_io_a_oe_o = ~dir_high;
  assign cascade_io_b_oe_o = dir_high;
  assign cascade_io_a_o = ~dir_high & casc_out;
  assign cascade_io_b_o = dir_high & casc_out;

  // ==========================================================
  // drive level selection
  // ==========================================================
  // data 1 selects the on rails, 0 the deselect rails; polarity flips pairs
  function automatic logic [LW-1:0] pick_level(
    input logic bit_on,
    input logic seg,
    input logic pol,
    input logic bl_n
  );
    lcd_drv_pkg::level_type lv;
    if (!bl_n) begin
      lv = lcd_drv_pkg::LEVEL_VSS;
    end else if (seg) begin
      lv = bit_on ? (pol ? lcd_drv_pkg::LEVEL_BIAS_TOP : lcd_drv_pkg::LEVEL_VSS) :
        (pol ? lcd_drv_pkg::LEVEL_BIAS_LOWER_MID : lcd_drv_pkg::LEVEL_BIAS_UPPER_MID);
    end else begin
      lv = bit_on ? (pol ? lcd_drv_pkg::LEVEL_VSS : lcd_drv_pkg::LEVEL_BIAS_TOP) :
        (pol ? lcd_drv_pkg::LEVEL_BIAS_UPPER_MID : lcd_drv_pkg::LEVEL_BIAS_LOWER_MID);
    end
    return lv;
  endfunction
  logic [NUM_OUTPUTS*LW-1:0] level_ff;
  logic [NUM_OUTPUTS*LW-1:0] nxt_level;
  always_comb begin
    nxt_level = '0;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      nxt_level[i*LW +: LW] = pick_level(line_ff[i], seg_mode, ac_pol, blank_n);
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_ff <= '0;
    end else begin
      level_ff <= nxt_level;
    end
  end
  assign lcd_outputs_o = level_ff;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  group_cnt_range_a: assert property (group_cnt_ff <= lcd_drv_pkg::LAST_GROUP)
    else $error("group counter beyond last group");
  strobe_resets_a: assert property (strobe_fall |=> state_ff == lcd_drv_pkg::CAP_IDLE
    && group_cnt_ff == lcd_drv_pkg::FIRST_GROUP && !half_ff)
    else $error("strobe did not reset capture");
  idle_no_capture_a: assert property (state_ff != lcd_drv_pkg::CAP_SELECTED
    |=> $stable(data_latch_ff))
    else $error("data latch changed while not selected");
  done_holds_a: assert property (state_ff == lcd_drv_pkg::CAP_DONE && !strobe_fall
    |=> state_ff == lcd_drv_pkg::CAP_DONE)
    else $error("left done without strobe");
  terminal_select_a: assert property (seg_mode && dir_high && group_ready && last_group
    && !strobe_fall |=> !cascade_io_b_o && cascade_io_b_oe_o)
    else $error("cascade select not asserted after last group");
  line_copy_a: assert property (strobe_fall && seg_mode && blank_n
    |=> line_ff == $past(data_latch_ff))
    else $error("line latch missed data latch copy");
  common_shift_a: assert property (strobe_fall && !seg_mode && blank_n && dir_high
    |=> line_ff[NUM_OUTPUTS-1:1] == $past(line_ff[NUM_OUTPUTS-2:0]))
    else $error("common shift wrong");
  blank_clear_a: assert property (!blank_n |=> line_ff == '0 &&
    level_ff[LW-1:0] == lcd_drv_pkg::LEVEL_VSS)
    else $error("blank did not clear and ground");
  cascade_roles_a: assert property (cascade_io_a_oe_o != cascade_io_b_oe_o)
    else $error("cascade pins not one in one out");
  cascade_shift_a: assert property (strobe_fall && !seg_mode && blank_n && dir_high
    |=> cascade_io_b_o == $past(line_ff[NUM_OUTPUTS-2]))
    else $error("common shift output not on cascade pin");
  nibble_pair_a: assert property (take_sample && !wide_bus && !half_ff && !strobe_fall
    |-> !group_ready ##1 half_ff)
    else $error("first nibble formed a group");

  full_line_c: cover property (group_ready && last_group);
  common_shift_c: cover property (strobe_fall && !seg_mode);
  nibble_mode_c: cover property (group_ready && !wide_bus);
  blank_release_c: cover property (!blank_n ##1 blank_n);
endmodule
`default_nettype wire

//--- verification/lcd_ctrl_model.sv
// Purpose: model of the external timing controller's pixel link
// Assumes: pixel clock period 160 ns, clock stands low between frames
// Notes: outside frames the data pins show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module lcd_ctrl_model (
  output logic pixel_shift_clock_o,
  output logic [7:0] pixel_in_o
);
  // ===
  // link driving
  initial begin
    pixel_shift_clock_o = 1'b0;
    pixel_in_o = 8'h00;
  end

  // data changes with the rising edge, the device takes it at the falling edge
  task automatic sample(input logic [7:0] d);
    pixel_in_o = d;
    pixel_shift_clock_o = 1'b1;
    #80;
    pixel_shift_clock_o = 1'b0;
    #80;
  endtask

  task automatic send(input logic [7:0] b, input logic w);
    if (w) begin
      sample(b);
    end else begin
      sample({~b[3:0], b[3:0]});
      sample({~b[7:4], b[7:4]});
    end
    pixel_in_o = ~pixel_in_o;
  endtask

  // single edge pair so the link flops see reset
  task automatic tick();
    pixel_shift_clock_o = 1'b1;
    #2;
    pixel_shift_clock_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: self-checking bench for the lcd segment/common driver core
// Assumes: cascade select active low, level codes as in the package
// Notes: drivers queue expected results, a monitor compares them
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {string name; int kind; logic [319:0] v;} note_type;
  logic clock_i, rst_n_i, strobe, pol, blank_n, wide, seg, dir, a_drv, b_drv;
  logic a_o, a_oe, b_o, b_oe, pclk;
  logic [7:0] pdat;
  logic [319:0] lcd, seen;
  logic [159:0] dlat;
  note_type notes[$];
  note_type nt;
  int err_total, check_count, seed;
  event look_ev;
  wire a_pin = a_oe ? a_o : a_drv;
  wire b_pin = b_oe ? b_o : b_drv;
  wire casc_out = dir ? b_o : a_o;

  lcd_ctrl_model u_lcd_ctrl_model (.pixel_shift_clock_o(pclk), .pixel_in_o(pdat));
  lcd_seg_com_driver_logic u_lcd_seg_com_driver_logic (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pixel_shift_clock_i(pclk), .pixel_in_i(pdat),
    .line_strobe_i(strobe), .ac_polarity_in_i(pol), .blank_outputs_n_i(blank_n),
    .bus_width_select_i(wide), .segment_mode_i(seg), .fill_direction_i(dir),
    .cascade_io_a_i(a_pin), .cascade_io_a_o(a_o), .cascade_io_a_oe_o(a_oe),
    .cascade_io_b_i(b_pin), .cascade_io_b_o(b_o), .cascade_io_b_oe_o(b_oe),
    .lcd_outputs_o(lcd)
  );

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // ===
  // expected levels
  function automatic logic [319:0] lv(input logic [159:0] ln, input logic s, input logic p,
                                      input logic bn);
    logic [1:0] c;
    lv = 320'h0;
    for (int i = 0; i < 160; i++) begin
      if (!bn) c = 2'h3;
      else if (s) c = ln[i] ? (p ? 2'h0 : 2'h3) : (p ? 2'h2 : 2'h1);
      else c = ln[i] ? (p ? 2'h3 : 2'h0) : (p ? 2'h1 : 2'h2);
      lv[2*i +: 2] = c;
    end
  endfunction

  // ===
  // checking
  task automatic note(input string n, input int k, input logic [319:0] v);
    notes.push_back('{n, k, v});
    repeat (8) @(posedge clock_i);
    ->look_ev;
    @(negedge clock_i);
  endtask

  initial forever begin
    @(look_ev);
    #1;
    nt = notes.pop_front();
    seen = (nt.kind == 2) ? {318'h0, a_oe, b_oe} : nt.kind ? {319'h0, casc_out} : lcd;
    check_count++;
    if (seen !== nt.v) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nt.name, nt.v, seen);
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ===
  // stimulus
  task automatic do_reset(input logic s, input logic w, input logic d);
    @(negedge clock_i);
    seg = s;
    wide = w;
    dir = d;
    rst_n_i = 1'b0;
    u_lcd_ctrl_model.tick();
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (12) @(negedge clock_i);
    note("cascade_oe", 2, {318'h0, !d, d});
  endtask

  task automatic strobe_fall();
    @(negedge clock_i);
    strobe = 1'b1;
    repeat (6) @(negedge clock_i);
    strobe = 1'b0;
    repeat (6) @(negedge clock_i);
  endtask

  task automatic shift_in(input logic v);
    @(negedge clock_i);
    if (dir) a_drv = v;
    else b_drv = v;
    strobe_fall();
  endtask

  task automatic frame(input logic sel, input int n);
    logic [7:0] b;
    int idx;
    @(negedge clock_i);
    if (dir) a_drv = !sel;
    else b_drv = !sel;
    repeat (10) @(negedge clock_i);
    for (int g = 0; g < n; g++) begin
      b = 8'($random(seed));
      u_lcd_ctrl_model.send(b, wide);
      for (int k = 0; k < 8; k++) begin
        idx = g * 8 + k;
        if (sel && g < 20) dlat[dir ? idx : 159 - idx] = b[k];
      end
      if (sel && g == 18) note("cascade_early", 1, 320'h1);
    end
    if (sel) begin
      idx = 0;
      while (casc_out !== 1'b0 && idx < 40) begin
        @(negedge clock_i);
        idx++;
      end
      if (idx == 40) begin
        err_total++;
        $display("CHECK FAILED cascade_wait expected 0 seen %b", casc_out);
        final_report();
      end else begin
        note("cascade_done", 1, 320'h0);
      end
    end
    @(negedge clock_i);
    a_drv = 1'b1;
    b_drv = 1'b1;
  endtask

  initial begin
    seed = 83532;
    err_total = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    strobe = 1'b0;
    pol = 1'b1;
    blank_n = 1'b1;
    wide = 1'b1;
    seg = 1'b1;
    dir = 1'b1;
    a_drv = 1'b1;
    b_drv = 1'b1;
    dlat = 160'h0;
    do_reset(1'b1, 1'b1, 1'b1);
    frame(1'b1, 21);
    strobe_fall();
    note("line_seg8", 0, lv(dlat, 1'b1, pol, 1'b1));
    $display("test seg8 done");
    pol = 1'b0;
    frame(1'b0, 20);
    strobe_fall();
    note("line_unselected", 0, lv(dlat, 1'b1, pol, 1'b1));
    $display("test unselected done");
    blank_n = 1'b0;
    frame(1'b1, 20);
    note("line_blank", 0, lv(dlat, 1'b1, pol, 1'b0));
    blank_n = 1'b1;
    note("line_deselect", 0, lv(160'h0, 1'b1, pol, 1'b1));
    strobe_fall();
    note("line_after_blank", 0, lv(dlat, 1'b1, pol, 1'b1));
    $display("test blank done");
    do_reset(1'b1, 1'b0, 1'b0);
    frame(1'b1, 20);
    strobe_fall();
    note("line_seg4", 0, lv(dlat, 1'b1, pol, 1'b1));
    $display("test seg4 done");
    for (int d = 1; d >= 0; d--) begin
      do_reset(1'b0, 1'b1, d[0]);
      pol = d[0];
      shift_in(1'b1);
      shift_in(1'b0);
      shift_in(1'b0);
      note("line_common", 0, lv(d ? 160'h4 : 160'h4 << 155, 1'b0, pol, 1'b1));
      $display("test common done");
    end
    repeat (4) @(negedge clock_i);
    if (notes.size() != 0) err_total++;
    final_report();
  end
endmodule
`default_nettype wire
